// ===== dprpc_consts.vh
// Constants for the dual-port RAM port control block
//
// Notes on behaviour
// - Reader sees new data one cycle later; with skew short, two cycles later. Both ports share one clock here; the reader always sees it one cycle later.
// - Counter wrap flag always driven; low when unmasked counter reaches its maximum.
// - Topmost address is the second port's mailbox location.
// - Mailbox flag sets on writer's clock edge, clears on reader's clock edge.
// - Deselect floats data; both selects with write write the selected byte lanes; read with gate low drives.
// - Output gate acts asynchronously; high keeps data lines in high impedance.
// - Select changes reach the data outputs after one cycle of latency.
// - Counter left incrementing after wrapping to its loaded value repeats the block.
// - Data output drive state follows controls registered in the previous cycle.
`ifndef DPRPC_CONSTS_VH
`define DPRPC_CONSTS_VH

// ****************************************************************
// Array geometry
// ****************************************************************
`define DPRPC_ADDR_W      19
`define DPRPC_DATA_W      18
`define DPRPC_DEPTH       524288
`define DPRPC_LANE_LO_MSB 8
`define DPRPC_LANE_HI_LSB 9
`define DPRPC_CNT_MASK    19'h7ffff
`define DPRPC_ADDR_RST    19'h00000

// ****************************************************************
// Mailbox locations
// ****************************************************************
`define DPRPC_MBOX_B      19'h7ffff
`define DPRPC_MBOX_A      19'h7fffe

// ****************************************************************
// Timing
// ****************************************************************
`define DPRPC_CLK_PERIOD_NS 10
`define DPRPC_SEL_LAT_NS    10
`define DPRPC_SEL_LAT_CYC   ((`DPRPC_SEL_LAT_NS + `DPRPC_CLK_PERIOD_NS - 1) / `DPRPC_CLK_PERIOD_NS)

// ****************************************************************
// Register port
// ****************************************************************
`define DPRPC_REG_STATUS  2'h0
`define DPRPC_REG_IRQMASK 2'h1
`define DPRPC_REG_FLAGS   2'h2
`define DPRPC_IRQMASK_RST 4'h0
`define DPRPC_ST_MBOX_A   0
`define DPRPC_ST_MBOX_B   1
`define DPRPC_ST_WRAP_A   2
`define DPRPC_ST_WRAP_B   3

`endif

// ===== dprpc_top.v
// Port control of a synchronous true dual-port RAM with mailbox and counters
`timescale 1ns/1ps
`include "dprpc_consts.vh"

module dprpc_top (
  // Clock and reset
  input  wire                        clk,
  input  wire                        reset_n,
  // Port A controls
  input  wire                        aSelectActiveLow_n,
  input  wire                        aSelectActiveHigh,
  input  wire                        aReadNotWrite,
  input  wire                        aLowerByteLaneSelect_n,
  input  wire                        aUpperByteLaneSelect_n,
  input  wire                        aOutputGate_n,
  input  wire                        aAddrLoad_n,
  input  wire                        aCountEnable_n,
  input  wire [`DPRPC_ADDR_W-1:0]    aAddr,
  // Port A data and flags
  input  wire [`DPRPC_DATA_W-1:0]    aPortDataLinesIn,
  output wire [`DPRPC_DATA_W-1:0]    aPortDataLinesOut,
  output wire                        aPortDataLinesOe,
  output wire                        aCounterWrapFlag_n,
  output wire                        aMailboxFlag_n,
  // Port B controls
  input  wire                        bSelectActiveLow_n,
  input  wire                        bSelectActiveHigh,
  input  wire                        bReadNotWrite,
  input  wire                        bLowerByteLaneSelect_n,
  input  wire                        bUpperByteLaneSelect_n,
  input  wire                        bOutputGate_n,
  input  wire                        bAddrLoad_n,
  input  wire                        bCountEnable_n,
  input  wire [`DPRPC_ADDR_W-1:0]    bAddr,
  // Port B data and flags
  input  wire [`DPRPC_DATA_W-1:0]    bPortDataLinesIn,
  output wire [`DPRPC_DATA_W-1:0]    bPortDataLinesOut,
  output wire                        bPortDataLinesOe,
  output wire                        bCounterWrapFlag_n,
  output wire                        bMailboxFlag_n,
  // Register port
  input  wire [1:0]                  regAddr,
  input  wire [7:0]                  regWrData,
  input  wire                        regWrite,
  input  wire                        regRead,
  output wire [7:0]                  regRdData,
  // Interrupt
  output wire                        irq
);

  // ****************************************************************
  // Storage and per-port state
  // ****************************************************************
  reg  [`DPRPC_DATA_W-1:0] mem         [0:`DPRPC_DEPTH-1];
  reg  [`DPRPC_ADDR_W-1:0] cnt_q       [0:1];
  reg  [`DPRPC_ADDR_W-1:0] startAddr_q [0:1];
  reg  [`DPRPC_DATA_W-1:0] rdData_q    [0:1];
  reg  [1:0]               drive_q;
  reg  [1:0]               wrapFlag_n_q;
  reg  [1:0]               mbox_q;
  reg  [1:0]               mbox_d;
  reg  [3:0]               status_q;
  reg  [3:0]               status_d;
  reg  [3:0]               irqMask_q;
  reg  [3:0]               irqMask_d;
  reg  [7:0]               regRdData_q;
  reg                      irq_q;
  integer                  p;
  integer                  pw;
  integer                  pm;

  // ****************************************************************
  // Port inputs gathered by index
  // ****************************************************************
  wire [1:0] selLow_n  = {bSelectActiveLow_n, aSelectActiveLow_n};
  wire [1:0] selHigh   = {bSelectActiveHigh, aSelectActiveHigh};
  wire [1:0] rdNotWr   = {bReadNotWrite, aReadNotWrite};
  wire [1:0] laneLo_n  = {bLowerByteLaneSelect_n, aLowerByteLaneSelect_n};
  wire [1:0] laneHi_n  = {bUpperByteLaneSelect_n, aUpperByteLaneSelect_n};
  wire [1:0] load_n    = {bAddrLoad_n, aAddrLoad_n};
  wire [1:0] countEn_n = {bCountEnable_n, aCountEnable_n};
  wire [`DPRPC_ADDR_W-1:0] addrIn  [0:1];
  wire [`DPRPC_DATA_W-1:0] dataIn  [0:1];
  wire [`DPRPC_ADDR_W-1:0] mboxOwn [0:1];

  assign addrIn[0]  = aAddr;
  assign addrIn[1]  = bAddr;
  assign dataIn[0]  = aPortDataLinesIn;
  assign dataIn[1]  = bPortDataLinesIn;
  assign mboxOwn[0] = `DPRPC_MBOX_A;
  assign mboxOwn[1] = `DPRPC_MBOX_B;

  // ****************************************************************
  // Per-port decode and address counter
  // ****************************************************************
  wire [1:0]               sel;
  wire [1:0]               wrEn;
  wire [1:0]               rdEn;
  wire [1:0]               wrapHit;
  wire [1:0]               mboxWrite;
  wire [1:0]               mboxRead;
  wire [`DPRPC_ADDR_W-1:0] accAddr [0:1];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gPort
      wire [`DPRPC_ADDR_W-1:0] plusOne;
      wire [`DPRPC_ADDR_W-1:0] stepped;
      wire                     atMax;
      wire                     stepping;
      assign plusOne  = cnt_q[g] + 19'h00001;
      assign atMax    = (cnt_q[g] & `DPRPC_CNT_MASK) == `DPRPC_CNT_MASK;
      assign stepping = load_n[g] & ~countEn_n[g];
      assign stepped  = atMax ? startAddr_q[g] :
                        ((cnt_q[g] & ~`DPRPC_CNT_MASK) |
                         (plusOne & `DPRPC_CNT_MASK));
      assign accAddr[g] = ~load_n[g] ? addrIn[g] :
                          (stepping ? stepped : cnt_q[g]);
      assign wrapHit[g] = stepping & ~atMax &
                          ((stepped & `DPRPC_CNT_MASK) == `DPRPC_CNT_MASK);
      assign sel[g]  = ~selLow_n[g] & selHigh[g];
      assign wrEn[g] = sel[g] & ~rdNotWr[g];
      assign rdEn[g] = sel[g] & rdNotWr[g];
      assign mboxWrite[g] = wrEn[g] & ~(laneLo_n[g] & laneHi_n[g]) &
                            (accAddr[g] == mboxOwn[1-g]);
      assign mboxRead[g]  = rdEn[g] & (accAddr[g] == mboxOwn[g]);
    end
  endgenerate

  // ****************************************************************
  // Array writes, byte lanes
  // ****************************************************************
  always @(posedge clk) begin
    for (pw = 0; pw < 2; pw = pw + 1) begin
      if (wrEn[pw] && !laneLo_n[pw]) begin
        mem[accAddr[pw]][`DPRPC_LANE_LO_MSB:0] <=
          dataIn[pw][`DPRPC_LANE_LO_MSB:0];
      end
      if (wrEn[pw] && !laneHi_n[pw]) begin
        mem[accAddr[pw]][`DPRPC_DATA_W-1:`DPRPC_LANE_HI_LSB] <=
          dataIn[pw][`DPRPC_DATA_W-1:`DPRPC_LANE_HI_LSB];
      end
    end
  end

  // ****************************************************************
  // Read pipeline, counters and wrap flags
  // ****************************************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (p = 0; p < 2; p = p + 1) begin
        cnt_q[p]       <= `DPRPC_ADDR_RST;
        startAddr_q[p] <= `DPRPC_ADDR_RST;
        rdData_q[p]    <= {`DPRPC_DATA_W{1'b0}};
      end
      drive_q      <= 2'h0;
      wrapFlag_n_q <= 2'h3;
    end else begin
      for (p = 0; p < 2; p = p + 1) begin
        cnt_q[p] <= accAddr[p];
        if (!load_n[p]) begin
          startAddr_q[p] <= addrIn[p];
        end
        if (rdEn[p]) begin
          rdData_q[p] <= mem[accAddr[p]];
        end
      end
      drive_q      <= rdEn;
      wrapFlag_n_q <= ~wrapHit;
    end
  end

  // ****************************************************************
  // Mailbox flags
  // ****************************************************************
  always @* begin
    mbox_d = mbox_q;
    for (pm = 0; pm < 2; pm = pm + 1) begin
      // clear on owner read, set wins
      if (mboxRead[pm]) begin
        mbox_d[pm] = 1'b0;
      end
      if (mboxWrite[1-pm]) begin
        mbox_d[pm] = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mbox_q <= 2'h0;
    end else begin
      mbox_q <= mbox_d;
    end
  end

  // ****************************************************************
  // Register port and interrupt
  // ****************************************************************
  always @* begin
    status_d = status_q;
    if (regRead && regAddr == `DPRPC_REG_STATUS) begin
      status_d = 4'h0;
    end
    if (mboxWrite[1]) begin
      status_d[`DPRPC_ST_MBOX_A] = 1'b1;
    end
    if (mboxWrite[0]) begin
      status_d[`DPRPC_ST_MBOX_B] = 1'b1;
    end
    if (wrapHit[0]) begin
      status_d[`DPRPC_ST_WRAP_A] = 1'b1;
    end
    if (wrapHit[1]) begin
      status_d[`DPRPC_ST_WRAP_B] = 1'b1;
    end
    irqMask_d = irqMask_q;
    if (regWrite && regAddr == `DPRPC_REG_IRQMASK) begin
      irqMask_d = regWrData[3:0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q    <= 4'h0;
      irqMask_q   <= `DPRPC_IRQMASK_RST;
      regRdData_q <= 8'h00;
      irq_q       <= 1'b0;
    end else begin
      status_q  <= status_d;
      irqMask_q <= irqMask_d;
      irq_q     <= |(status_d & irqMask_d);
      if (regRead) begin
        case (regAddr)
          `DPRPC_REG_STATUS:  regRdData_q <= {4'h0, status_q};
          `DPRPC_REG_IRQMASK: regRdData_q <= {4'h0, irqMask_q};
          `DPRPC_REG_FLAGS:   regRdData_q <= {4'h0, ~wrapFlag_n_q, mbox_q};
          default:            regRdData_q <= 8'h00;
        endcase
      end else begin
        regRdData_q <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign aPortDataLinesOut  = rdData_q[0];
  assign bPortDataLinesOut  = rdData_q[1];
  assign aPortDataLinesOe   = drive_q[0] & ~aOutputGate_n;
  assign bPortDataLinesOe   = drive_q[1] & ~bOutputGate_n;
  assign aCounterWrapFlag_n = wrapFlag_n_q[0];
  assign bCounterWrapFlag_n = wrapFlag_n_q[1];
  assign aMailboxFlag_n     = ~mbox_q[0];
  assign bMailboxFlag_n     = ~mbox_q[1];
  assign regRdData          = regRdData_q;
  assign irq                = irq_q;

endmodule

// ===== dprpc_chk_assertions.sv
// Concurrent checks on the port control block ports
`timescale 1ns/1ps
`include "dprpc_consts.vh"
module dprpc_chk (
  // Watched ports
  input wire                     clk,
  input wire                     reset_n,
  input wire                     aSelectActiveLow_n,
  input wire                     aSelectActiveHigh,
  input wire                     aReadNotWrite,
  input wire                     aLowerByteLaneSelect_n,
  input wire                     aUpperByteLaneSelect_n,
  input wire                     aOutputGate_n,
  input wire                     aAddrLoad_n,
  input wire                     aCountEnable_n,
  input wire [`DPRPC_ADDR_W-1:0] aAddr,
  input wire                     aPortDataLinesOe,
  input wire                     aCounterWrapFlag_n,
  input wire                     aMailboxFlag_n,
  input wire                     bSelectActiveLow_n,
  input wire                     bSelectActiveHigh,
  input wire                     bReadNotWrite,
  input wire                     bLowerByteLaneSelect_n,
  input wire                     bUpperByteLaneSelect_n,
  input wire                     bAddrLoad_n,
  input wire [`DPRPC_ADDR_W-1:0] bAddr,
  input wire                     bMailboxFlag_n,
  input wire                     regRead,
  input wire [7:0]               regRdData
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire aSel = !aSelectActiveLow_n && aSelectActiveHigh;
  wire bSel = !bSelectActiveLow_n && bSelectActiveHigh;
  wire aLane = !aLowerByteLaneSelect_n || !aUpperByteLaneSelect_n;
  wire bLane = !bLowerByteLaneSelect_n || !bUpperByteLaneSelect_n;
  wire aWrTop = aSel && !aReadNotWrite && aLane && !aAddrLoad_n
                && aAddr == `DPRPC_MBOX_B;
  wire bRdTop = bSel && bReadNotWrite && !bAddrLoad_n
                && bAddr == `DPRPC_MBOX_B;
  sequence aStepToTop;
    !aAddrLoad_n && aAddr == `DPRPC_MBOX_A ##1
      aAddrLoad_n && !aCountEnable_n;
  endsequence
  sequence aReadThenGate;
    aSel && aReadNotWrite ##1 !aOutputGate_n;
  endsequence
  a_gate_floats: assert property (aOutputGate_n |-> !aPortDataLinesOe)
    else $error("data driven while gate high");
  a_read_drives: assert property (aReadThenGate |-> aPortDataLinesOe)
    else $error("read did not drive data lines");
  a_desel_floats: assert property (!aSel |=> !aPortDataLinesOe)
    else $error("data driven after deselect");
  a_write_floats: assert property
    (aSel && !aReadNotWrite |=> !aPortDataLinesOe)
    else $error("data driven after write");
  a_mbox_set: assert property (aWrTop |=> !bMailboxFlag_n)
    else $error("mailbox flag not set by write");
  a_mbox_clear: assert property (bRdTop && !aWrTop |=> bMailboxFlag_n)
    else $error("mailbox flag not cleared by read");
  a_mbox_other: assert property
    (bSel && !bReadNotWrite && bLane && !bAddrLoad_n
     && bAddr == `DPRPC_MBOX_A |=> !aMailboxFlag_n)
    else $error("other port mailbox flag not set");
  a_wrap_low: assert property (aStepToTop |=> !aCounterWrapFlag_n)
    else $error("wrap flag not low at counter maximum");
  a_reg_idle: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data not zero outside read answer");
endmodule
bind dprpc_top dprpc_chk chk_u (.*);

// ===== dprpc_host.sv
// Host view of one port's two-way data lines
`timescale 1ns/1ps
`include "dprpc_consts.vh"
module dprpc_host (
  // Design side
  input  wire                     clk,
  input  wire                     oe,
  input  wire [`DPRPC_DATA_W-1:0] dataOut,
  // Resolved lines
  output wire [`DPRPC_DATA_W-1:0] lines
);
  reg [`DPRPC_DATA_W-1:0] last_q = 18'h00000;
  // skew and collisions: bench never reads mid-write wrongly
  always @(posedge clk) if (oe) last_q <= dataOut;
  // Released lines show the inverse of the last driven value
  assign lines = oe ? dataOut : ~last_q;
endmodule

// ===== test_dual_port_ram_port_control.sv
// Directed test of port control, mailbox, counter and register port
`timescale 1ns/1ps
`include "dprpc_consts.vh"
module test_dual_port_ram_port_control;
  reg                      clk = 1'b0;
  reg                      reset_n = 1'b0;
  reg                      aSelectActiveLow_n, aSelectActiveHigh;
  reg                      aReadNotWrite, aOutputGate_n;
  reg                      aLowerByteLaneSelect_n, aUpperByteLaneSelect_n;
  reg                      aAddrLoad_n, aCountEnable_n;
  reg                      bSelectActiveLow_n, bSelectActiveHigh;
  reg                      bReadNotWrite, bOutputGate_n;
  reg                      bLowerByteLaneSelect_n, bUpperByteLaneSelect_n;
  reg                      bAddrLoad_n, bCountEnable_n;
  reg [`DPRPC_ADDR_W-1:0]  aAddr, bAddr;
  reg [`DPRPC_DATA_W-1:0]  aPortDataLinesIn, bPortDataLinesIn;
  wire [`DPRPC_DATA_W-1:0] aPortDataLinesOut, bPortDataLinesOut, aBus, bBus;
  wire                     aPortDataLinesOe, aCounterWrapFlag_n;
  wire                     bPortDataLinesOe, bCounterWrapFlag_n;
  wire                     aMailboxFlag_n, bMailboxFlag_n, irq;
  reg [1:0]                regAddr = 2'h0;
  reg [7:0]                regWrData = 8'h00;
  reg                      regWrite = 1'b0;
  reg                      regRead = 1'b0;
  wire [7:0]               regRdData;
  integer                  err_total = 0;
  integer                  cmp_count = 0;
  integer                  i;
  localparam [8:0]         DSL = {3'h2, 3'h5, 3'h0};
  dprpc_top dut_u (.*);
  dprpc_host hostA (.clk(clk), .oe(aPortDataLinesOe),
                    .dataOut(aPortDataLinesOut), .lines(aBus));
  dprpc_host hostB (.clk(clk), .oe(bPortDataLinesOe),
                    .dataOut(bPortDataLinesOut), .lines(bBus));
  always #5 clk = ~clk;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Command: 0/5 deselect, 1 read, 2 write, 3 step, 4 low lane, 6 no lane
  // lanes chosen per command
  function [6:0] ctl(input [2:0] c);
    ctl = {c == 3'h0, c != 3'h5, c[0] | (c == 3'h0), c == 3'h6,
           c[2] & !c[0], c == 3'h3, c != 3'h3};
  endfunction
  task cyc(input [2:0] ca, input [18:0] xa, input [17:0] xd,
           input [2:0] cb, input [18:0] ya, input [17:0] yd);
    begin
      @(posedge clk);
      {aSelectActiveLow_n, aSelectActiveHigh, aReadNotWrite,
       aLowerByteLaneSelect_n, aUpperByteLaneSelect_n, aAddrLoad_n,
       aCountEnable_n} <= ctl(ca);
      {bSelectActiveLow_n, bSelectActiveHigh, bReadNotWrite,
       bLowerByteLaneSelect_n, bUpperByteLaneSelect_n, bAddrLoad_n,
       bCountEnable_n} <= ctl(cb);
      {aAddr, aPortDataLinesIn, bAddr, bPortDataLinesIn} <= {xa, xd, ya, yd};
    end
  endtask
  task chk(input string nm, input [18:0] seen, input [18:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task regW(input [1:0] ad, input [7:0] d);
    begin
      @(posedge clk);
      {regAddr, regWrData, regWrite} <= {ad, d, 1'b1};
      @(posedge clk);
      regWrite <= 1'b0;
    end
  endtask
  task regR(input [1:0] ad, input [7:0] exp);
    begin
      @(posedge clk);
      {regAddr, regRead} <= {ad, 1'b1};
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk("regRdData", regRdData, exp);
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #400000;
    err_total = err_total + 1;
    test_done;
  end
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    {aOutputGate_n, bOutputGate_n} = 2'b00;
    {aSelectActiveLow_n, aSelectActiveHigh, aReadNotWrite,
     aLowerByteLaneSelect_n, aUpperByteLaneSelect_n, aAddrLoad_n,
     aCountEnable_n} = ctl(3'h0);
    {bSelectActiveLow_n, bSelectActiveHigh, bReadNotWrite,
     bLowerByteLaneSelect_n, bUpperByteLaneSelect_n, bAddrLoad_n,
     bCountEnable_n} = ctl(3'h0);
    {aAddr, aPortDataLinesIn, bAddr, bPortDataLinesIn} = 74'h0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk("rstFlags", {aMailboxFlag_n, bMailboxFlag_n, aCounterWrapFlag_n,
         aPortDataLinesOe, irq}, 18'h1c);
    regW(2'h1, 8'h0f);
    cyc(3'h2, 19'h0000a, 18'h12345, 3'h0, 19'h0, 18'h0);
    cyc(3'h2, 19'h0000a, 18'h00abc, 3'h1, 19'h0000a, 18'h0);
    cyc(3'h4, 19'h0000a, 18'h3ffff, 3'h1, 19'h0000a, 18'h0);
    #1 chk("bOld", bBus, 18'h12345);
    cyc(3'h0, 19'h0, 18'h0, 3'h1, 19'h0000a, 18'h0);
    #1 chk("bNew", bBus, 18'h00abc);
    cyc(3'h1, 19'h0000a, 18'h0, 3'h0, 19'h0, 18'h0);
    #1 chk("bLane", bBus, 18'h00bff);
    cyc(3'h1, 19'h0000a, 18'h0, 3'h0, 19'h0, 18'h0);
    #1 chk("bOff", bPortDataLinesOe, 18'h0);
    aOutputGate_n = 1'b1;
    #1 chk("gateHi", aPortDataLinesOe, 18'h0);
    aOutputGate_n = 1'b0;
    #1 chk("gateLo", aBus, 18'h00bff);
    for (i = 0; i < 3; i = i + 1) begin
      cyc(3'h1, 19'h0000a, 18'h0, 3'h0, 19'h0, 18'h0);
      cyc(DSL[i*3 +: 3], 19'h0000a, 18'h0, 3'h0, 19'h0, 18'h0);
      #1 chk("oeLatency", aPortDataLinesOe, 18'h1);
      cyc(3'h1, 19'h0000a, 18'h0, 3'h0, 19'h0, 18'h0);
      #1 chk("oeOff", aPortDataLinesOe, 18'h0);
    end
    cyc(3'h6, `DPRPC_MBOX_B, 18'h00001, 3'h0, 19'h0, 18'h0);
    cyc(3'h2, `DPRPC_MBOX_B, 18'h00001, 3'h0, 19'h0, 18'h0);
    #1 chk("noLane", bMailboxFlag_n, 18'h1);
    cyc(3'h0, 19'h0, 18'h0, 3'h0, 19'h0, 18'h0);
    #1 chk("mboxB", {bMailboxFlag_n, irq}, 18'h1);
    regR(2'h2, 8'h02);
    regR(2'h0, 8'h02);
    regR(2'h0, 8'h00);
    regR(2'h3, 8'h00);
    chk("irqClr", irq, 18'h0);
    cyc(3'h0, 19'h0, 18'h0, 3'h1, `DPRPC_MBOX_B, 18'h0);
    cyc(3'h0, 19'h0, 18'h0, 3'h0, 19'h0, 18'h0);
    #1 chk("mboxBClr", bMailboxFlag_n, 18'h1);
    regW(2'h1, 8'h00);
    cyc(3'h0, 19'h0, 18'h0, 3'h2, `DPRPC_MBOX_A, 18'h2a5a5);
    cyc(3'h0, 19'h0, 18'h0, 3'h0, 19'h0, 18'h0);
    #1 chk("mboxA", {aMailboxFlag_n, irq}, 18'h0);
    regR(2'h0, 8'h01);
    regW(2'h1, 8'h0f);
    cyc(3'h1, `DPRPC_MBOX_A, 18'h0, 3'h0, 19'h0, 18'h0);
    cyc(3'h3, 19'h0, 18'h0, 3'h0, 19'h0, 18'h0);
    cyc(3'h3, 19'h0, 18'h0, 3'h0, 19'h0, 18'h0);
    #1 chk("wrapLow", {aCounterWrapFlag_n, aBus}, 18'h00001);
    cyc(3'h0, 19'h0, 18'h0, 3'h0, 19'h0, 18'h0);
    #1 chk("retransmit", aBus, 18'h2a5a5);
    chk("mboxAClr", {aCounterWrapFlag_n, aMailboxFlag_n, irq}, 18'h7);
    regR(2'h0, 8'h04);
    test_done;
  end
endmodule
